/* File: rtl/flash_susp_host.sv */
/*
 * Controller end: turns user operations into link requests, refuses the
 * operations that are prohibited while an erase or a program is suspended,
 * and holds back a suspend until the resume to suspend gap has passed.
 * Assumes the flash end reports its running and suspended state on the link.
 */
`timescale 1ns/1ps
module flash_susp_host
    import flash_susp_pkg::*;
#(
    parameter int RESUME_GAP = flash_susp_pkg::RESUME_GAP_CYC,
    parameter int GW = 16
) (
    input wire logic mclk,
    input wire logic sys_rst,
    flash_link.host lnk,
    input wire logic usr_valid,
    input wire flash_susp_pkg::op_kind_t usr_kind,
    input wire logic [23:0] usr_addr,
    output logic usr_ready,
    output logic usr_refused,
    output logic usr_done,
    output logic [7:0] usr_data
);
    import flash_susp_pkg::*;

    // Cycles the request path stays closed after issuing, so that the
    // flash end's status has caught up before the next decision.
    localparam logic [1:0] SETTLE = 2'd2;

    typedef struct packed {
        logic req_valid;
        logic [7:0] req_code;
        logic [23:0] req_addr;
        logic [GW-1:0] gap_cnt;
        logic [1:0] hold;
        logic pend;
        logic [23:0] ers_addr;
        logic [23:0] prg_addr;
        logic ready;
        logic refused;
        logic done;
        logic [7:0] data;
    } host_regs_t;

    host_regs_t s_r;
    host_regs_t s_nxt;
    logic busy;
    logic same_sector;
    logic same_page;
    logic take;

    always_comb begin
        s_nxt = s_r;
        s_nxt.req_valid = 1'b0;
        s_nxt.refused = 1'b0;
        s_nxt.done = lnk.rsp_valid;
        if (lnk.rsp_valid) begin
            s_nxt.data = lnk.rsp_data;
        end
        busy = lnk.erasing || lnk.programming || lnk.halting;
        same_sector = usr_addr[23:SECTOR_LSB]
            == s_r.ers_addr[23:SECTOR_LSB];
        same_page = usr_addr[23:PAGE_LSB] == s_r.prg_addr[23:PAGE_LSB];
        take = usr_valid && s_r.ready;

        if (s_r.gap_cnt != '0) begin
            s_nxt.gap_cnt = s_r.gap_cnt - GW'(1);
        end
        if (s_r.hold != 2'd0) begin
            s_nxt.hold = s_r.hold - 2'd1;
        end

        // A suspend held back by the gap goes out once the gap is over.
        if (s_r.pend && s_r.gap_cnt == '0) begin
            s_nxt.pend = 1'b0;
            s_nxt.req_valid = 1'b1;
            s_nxt.req_code = OP_SUSPEND;
            s_nxt.hold = SETTLE;
        end

        if (take) begin
            unique case (usr_kind)
                K_ERASE: begin
                    if (lnk.ers_susp || lnk.prg_susp || busy) begin
                        s_nxt.refused = 1'b1;
                    end else begin
                        s_nxt.req_valid = 1'b1;
                        s_nxt.req_code = OP_ERASE;
                        s_nxt.ers_addr = usr_addr;
                    end
                end
                K_PROGRAM: begin
                    if (lnk.prg_susp || busy) begin
                        s_nxt.refused = 1'b1;
                    end else if (lnk.ers_susp && same_sector) begin
                        s_nxt.refused = 1'b1;
                    end else begin
                        s_nxt.req_valid = 1'b1;
                        s_nxt.req_code = OP_PROGRAM;
                        s_nxt.prg_addr = usr_addr;
                    end
                end
                K_READ: begin
                    if (lnk.ers_susp && same_sector) begin
                        s_nxt.refused = 1'b1;
                    end else if (lnk.prg_susp && same_page) begin
                        s_nxt.refused = 1'b1;
                    end else begin
                        s_nxt.req_valid = 1'b1;
                        s_nxt.req_code = OP_READ;
                    end
                end
                K_SUSPEND: begin
                    if (s_r.gap_cnt != '0) begin
                        s_nxt.pend = 1'b1;
                    end else begin
                        s_nxt.req_valid = 1'b1;
                        s_nxt.req_code = OP_SUSPEND;
                    end
                end
                K_RESUME: begin
                    s_nxt.req_valid = 1'b1;
                    s_nxt.req_code = OP_RESUME;
                    s_nxt.gap_cnt = GW'(RESUME_GAP);
                end
                K_DISCOVER: begin
                    s_nxt.req_valid = 1'b1;
                    s_nxt.req_code = OP_DISCOVER;
                end
                default: begin
                    s_nxt.refused = 1'b1;
                end
            endcase
            s_nxt.req_addr = usr_addr;
            if (s_nxt.req_valid) begin
                s_nxt.hold = SETTLE;
            end
        end

        s_nxt.ready = (s_nxt.hold == 2'd0) && !s_nxt.pend
            && !s_nxt.req_valid;
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign lnk.req_valid = s_r.req_valid;
    assign lnk.req_code = s_r.req_code;
    assign lnk.req_addr = s_r.req_addr;
    assign usr_ready = s_r.ready;
    assign usr_refused = s_r.refused;
    assign usr_done = s_r.done;
    assign usr_data = s_r.data;

endmodule // flash_susp_host

/* File: rtl/flash_susp_pkg.sv */
/*
 * Shared constants for the suspend and resume link of a serial NOR flash:
 * instruction codes, the fields of the discovery parameter word and the
 * timing figures that both ends derive their cycle counts from.
 * Assumes a single 50 MHz clock shared by both ends.
 */
package flash_susp_pkg;

    localparam int CLK_NS = 20;

    // Instruction codes carried on the link.
    localparam logic [7:0] OP_SUSPEND = 8'h75;
    localparam logic [7:0] OP_RESUME = 8'h7A;
    localparam logic [7:0] OP_ERASE = 8'hD8;
    localparam logic [7:0] OP_PROGRAM = 8'h02;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_DISCOVER = 8'h5A;

    // Value returned for array reads and for unmapped discovery offsets.
    localparam logic [7:0] BLANK_BYTE = 8'hFF;

    // Fields of the suspend parameter word, most significant first.
    localparam logic SUSP_SUPPORTED = 1'b0;
    localparam logic [1:0] LAT_UNITS = 2'b10;
    localparam logic [4:0] LAT_COUNT = 5'b00101;
    localparam logic [3:0] GAP_COUNT = 4'b0001;
    localparam logic RESERVED_FUTURE_BIT = 1'b1;
    localparam logic [3:0] ERS_PROHIBIT = 4'b1110;
    localparam logic [3:0] PRG_PROHIBIT = 4'b1100;
    localparam logic [31:0] SUSP_WORD = {SUSP_SUPPORTED, LAT_UNITS,
        LAT_COUNT, GAP_COUNT, LAT_UNITS, LAT_COUNT, GAP_COUNT,
        RESERVED_FUTURE_BIT, ERS_PROHIBIT, PRG_PROHIBIT};

    // Byte offset of the least significant byte of the suspend word.
    localparam logic [7:0] SUSP_WORD_OFS = 8'h2C;

    // Suspend latency: (count + 1) units of 8 us, a longest time.
    localparam int LAT_UNIT_NS = 8000;
    localparam int SUSP_LAT_NS = (int'(LAT_COUNT) + 1) * LAT_UNIT_NS;
    localparam int SUSP_LAT_CYC = SUSP_LAT_NS / CLK_NS;

    // Resume to suspend gap: (count + 1) steps of 64 us, a least time.
    localparam int GAP_STEP_NS = 64000;
    localparam int RESUME_GAP_NS = (int'(GAP_COUNT) + 1) * GAP_STEP_NS;
    localparam int RESUME_GAP_CYC = (RESUME_GAP_NS + CLK_NS - 1) / CLK_NS;

    // Address bits that select a sector and a page.
    localparam int SECTOR_LSB = 16;
    localparam int PAGE_LSB = 9;

    typedef enum logic [2:0] {
        K_READ,
        K_ERASE,
        K_PROGRAM,
        K_SUSPEND,
        K_RESUME,
        K_DISCOVER
    } op_kind_t;

endpackage

/* File: rtl/flash_link.sv */
/*
 * Link between the flash controller and the flash suspend logic.
 * Assumes both ends run on the same clock; requests are one-cycle pulses.
 */
`timescale 1ns/1ps
interface flash_link;
    logic req_valid;
    logic [7:0] req_code;
    logic [23:0] req_addr;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic erasing;
    logic programming;
    logic halting;
    logic ers_susp;
    logic prg_susp;

    modport dev (
        input req_valid, req_code, req_addr,
        output rsp_valid, rsp_data, erasing, programming, halting,
        output ers_susp, prg_susp
    );
    modport host (
        output req_valid, req_code, req_addr,
        input rsp_valid, rsp_data, erasing, programming, halting,
        input ers_susp, prg_susp
    );
endinterface

/* File: rtl/flash_susp_dev.sv */
/*
 * Flash end: runs timed erase and program operations, halts them on a
 * suspend request within the advertised latency, resumes them, and serves
 * the discovery parameter word byte by byte.
 * Assumes the controller keeps the prohibitions that apply while suspended.
 */
`timescale 1ns/1ps
module flash_susp_dev
    import flash_susp_pkg::*;
#(
    parameter int ERASE_CYC = 50000,
    parameter int PROG_CYC = 5000,
    parameter int HALT_CYC = flash_susp_pkg::SUSP_LAT_CYC,
    parameter int CW = 20
) (
    input wire logic mclk,
    input wire logic sys_rst,
    flash_link.dev lnk
);
    import flash_susp_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROG, ST_HALT} dev_st_t;

    typedef struct packed {
        dev_st_t st;
        logic halt_prog;
        logic [CW-1:0] ers_left;
        logic [CW-1:0] prg_left;
        logic [CW-1:0] halt_cnt;
        logic ers_susp;
        logic prg_susp;
        logic erasing;
        logic programming;
        logic halting;
        logic rsp_valid;
        logic [7:0] rsp_data;
    } dev_regs_t;

    dev_regs_t s_r;
    dev_regs_t s_nxt;
    logic [7:0] ofs;

    always_comb begin
        s_nxt = s_r;
        s_nxt.rsp_valid = 1'b0;
        ofs = lnk.req_addr[7:0] - SUSP_WORD_OFS;
        unique case (s_r.st)
            ST_ERASE: begin
                if (s_r.ers_left <= CW'(1)) begin
                    s_nxt.ers_left = '0;
                    s_nxt.st = ST_IDLE;
                end else begin
                    s_nxt.ers_left = s_r.ers_left - CW'(1);
                end
            end
            ST_PROG: begin
                if (s_r.prg_left <= CW'(1)) begin
                    s_nxt.prg_left = '0;
                    s_nxt.st = ST_IDLE;
                end else begin
                    s_nxt.prg_left = s_r.prg_left - CW'(1);
                end
            end
            ST_HALT: begin
                // The operation stops making progress while it winds down.
                if (s_r.halt_cnt == '0) begin
                    s_nxt.st = ST_IDLE;
                    if (s_r.halt_prog) begin
                        s_nxt.prg_susp = 1'b1;
                    end else begin
                        s_nxt.ers_susp = 1'b1;
                    end
                end else begin
                    s_nxt.halt_cnt = s_r.halt_cnt - CW'(1);
                end
            end
            ST_IDLE: begin
            end
        endcase
        if (lnk.req_valid) begin
            unique case (lnk.req_code)
                OP_SUSPEND: begin
                    if (s_r.st == ST_ERASE || s_r.st == ST_PROG) begin
                        s_nxt.st = ST_HALT;
                        s_nxt.halt_prog = (s_r.st == ST_PROG);
                        s_nxt.halt_cnt = CW'(HALT_CYC - 1);
                    end
                    // Otherwise the flash is idle or already halting, and the request is
                    // dropped without touching any state.
                end
                OP_RESUME: begin
                    if (s_r.st == ST_IDLE && s_r.prg_susp) begin
                        s_nxt.prg_susp = 1'b0;
                        s_nxt.st = ST_PROG;
                    end else if (s_r.st == ST_IDLE && s_r.ers_susp) begin
                        s_nxt.ers_susp = 1'b0;
                        s_nxt.st = ST_ERASE;
                    end
                end
                OP_ERASE: begin
                    if (s_r.st == ST_IDLE && !s_r.ers_susp
                            && !s_r.prg_susp) begin
                        s_nxt.st = ST_ERASE;
                        s_nxt.ers_left = CW'(ERASE_CYC);
                    end
                end
                OP_PROGRAM: begin
                    if (s_r.st == ST_IDLE && !s_r.prg_susp) begin
                        s_nxt.st = ST_PROG;
                        s_nxt.prg_left = CW'(PROG_CYC);
                    end
                end
                OP_READ: begin
                    s_nxt.rsp_valid = 1'b1;
                    s_nxt.rsp_data = BLANK_BYTE;
                end
                OP_DISCOVER: begin
                    s_nxt.rsp_valid = 1'b1;
                    // Offsets with any upper address bit set are unmapped.
                    if (lnk.req_addr[23:8] == 16'h0000 && ofs < 8'h04) begin
                        s_nxt.rsp_data = SUSP_WORD[ofs[1:0]*8 +: 8];
                    end else begin
                        s_nxt.rsp_data = BLANK_BYTE;
                    end
                end
                default: begin
                end
            endcase
        end
        s_nxt.erasing = (s_nxt.st == ST_ERASE);
        s_nxt.programming = (s_nxt.st == ST_PROG);
        s_nxt.halting = (s_nxt.st == ST_HALT);
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign lnk.rsp_valid = s_r.rsp_valid;
    assign lnk.rsp_data = s_r.rsp_data;
    assign lnk.erasing = s_r.erasing;
    assign lnk.programming = s_r.programming;
    assign lnk.halting = s_r.halting;
    assign lnk.ers_susp = s_r.ers_susp;
    assign lnk.prg_susp = s_r.prg_susp;

endmodule // flash_susp_dev

/* File: test/flash_susp_asserts.sv */
/*
 * Checker for the suspend link between the controller end and the flash end.
 * Assumes one clock, an active-high asynchronous reset and link signals.
 */
`timescale 1ns/1ps
module flash_susp_asserts
    import flash_susp_pkg::*;
#(
    parameter int HALT_CYC = 5,
    parameter int RESUME_GAP = 20
) (
    input logic mclk,
    input logic sys_rst,
    input logic req_valid,
    input logic [7:0] req_code,
    input logic [23:0] req_addr,
    input logic rsp_valid,
    input logic [7:0] rsp_data,
    input logic erasing,
    input logic programming,
    input logic halting,
    input logic ers_susp,
    input logic prg_susp
);
    logic [23:0] ers_addr_r;
    logic [23:0] prg_addr_r;
    int gap_r;
    logic [7:0] disc_exp;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    always_comb begin
        case (req_addr)
            24'h00002C: disc_exp = 8'hEC;
            24'h00002D: disc_exp = 8'hA3;
            24'h00002E: disc_exp = 8'h18;
            24'h00002F: disc_exp = 8'h45;
            default: disc_exp = 8'hFF;
        endcase
    end

    // Last erase and program addresses, and cycles left of the resume gap.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ers_addr_r <= 24'h0;
            prg_addr_r <= 24'h0;
            gap_r <= 0;
        end else begin
            if (req_valid && req_code == OP_ERASE) ers_addr_r <= req_addr;
            if (req_valid && req_code == OP_PROGRAM) prg_addr_r <= req_addr;
            if (req_valid && req_code == OP_RESUME) gap_r <= RESUME_GAP - 1;
            else if (gap_r != 0) gap_r <= gap_r - 1;
        end
    end

    property p_disc_word;
        req_valid && req_code == OP_DISCOVER |=>
            rsp_valid && rsp_data == $past(disc_exp);
    endproperty
    a_disc_word: assert property (p_disc_word)
        else $error("discovery byte wrong");
    // The suspended flag shows HALT_CYC cycles after halting begins.
    property p_ers_halt;
        req_valid && req_code == 8'h75 && erasing |=>
            halting && !erasing ##HALT_CYC ers_susp;
    endproperty
    a_ers_halt: assert property (p_ers_halt)
        else $error("erase not halted in time");
    property p_prg_halt;
        req_valid && req_code == 8'h75 && programming |=>
            halting && !programming ##HALT_CYC prg_susp;
    endproperty
    a_prg_halt: assert property (p_prg_halt)
        else $error("program not halted in time");
    property p_idle_susp;
        req_valid && req_code == 8'h75 && !erasing && !programming
            && !halting |=> !halting && $stable({ers_susp, prg_susp});
    endproperty
    a_idle_susp: assert property (p_idle_susp)
        else $error("idle suspend changed state");
    property p_gap;
        req_valid && req_code == 8'h75 |-> gap_r == 0;
    endproperty
    a_gap: assert property (p_gap)
        else $error("suspend too soon after resume");
    property p_ers_nest;
        req_valid && req_code == OP_ERASE |-> !ers_susp && !prg_susp;
    endproperty
    a_ers_nest: assert property (p_ers_nest)
        else $error("erase while suspended");
    property p_prg_nest;
        req_valid && req_code == OP_PROGRAM |-> !prg_susp;
    endproperty
    a_prg_nest: assert property (p_prg_nest)
        else $error("program while program suspended");
    property p_ers_sector;
        req_valid && ers_susp && (req_code == OP_PROGRAM
            || req_code == OP_READ) |-> req_addr[23:16] != ers_addr_r[23:16];
    endproperty
    a_ers_sector: assert property (p_ers_sector)
        else $error("access to suspended sector");
    property p_prg_page;
        req_valid && prg_susp && req_code == OP_READ |->
            req_addr[23:9] != prg_addr_r[23:9];
    endproperty
    a_prg_page: assert property (p_prg_page)
        else $error("read of suspended page");

    c_ers_susp: cover property (req_valid && req_code == 8'h75 && erasing);
    c_prg_susp: cover property (req_valid && req_code == 8'h75 && programming);
    c_both: cover property (ers_susp && prg_susp);
endmodule // flash_susp_asserts

/* File: test/flash_suspend_resume_control_test.sv */
/*
 * Self-checking bench for the two flash ends joined by one link.
 * Assumes a 50 MHz clock and shortened operation and gap counts.
 */
`timescale 1ns/1ps
module flash_suspend_resume_control_test;
    import flash_susp_pkg::*;
    localparam int HALT = 5;
    localparam int GAP = 20;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic usr_valid = 1'b0;
    op_kind_t usr_kind = K_READ;
    logic [23:0] usr_addr = 24'h0;
    logic usr_ready;
    logic usr_refused;
    logic usr_done;
    logic [7:0] usr_data;
    int mismatches = 0;
    int checked = 0;
    op_kind_t k;
    logic [23:0] a;

    flash_link lnk();
    flash_susp_dev #(.ERASE_CYC(40), .PROG_CYC(60), .HALT_CYC(HALT),
        .CW(20)) u_flash_susp_dev (.mclk(mclk), .sys_rst(sys_rst), .lnk(lnk));
    flash_susp_host #(.RESUME_GAP(GAP), .GW(16)) u_flash_susp_host (
        .mclk(mclk), .sys_rst(sys_rst), .lnk(lnk), .usr_valid(usr_valid),
        .usr_kind(usr_kind), .usr_addr(usr_addr), .usr_ready(usr_ready),
        .usr_refused(usr_refused), .usr_done(usr_done), .usr_data(usr_data));
    flash_susp_asserts #(.HALT_CYC(HALT), .RESUME_GAP(GAP))
        u_flash_susp_asserts (.mclk(mclk), .sys_rst(sys_rst),
        .req_valid(lnk.req_valid), .req_code(lnk.req_code),
        .req_addr(lnk.req_addr), .rsp_valid(lnk.rsp_valid),
        .rsp_data(lnk.rsp_data), .erasing(lnk.erasing),
        .programming(lnk.programming), .halting(lnk.halting),
        .ers_susp(lnk.ers_susp), .prg_susp(lnk.prg_susp));

    initial begin
        forever #10 mclk = ~mclk;
    end

    function automatic logic [7:0] disc_byte(input logic [7:0] ofs);
        logic [31:0] w;
        w = 32'h4518A3EC;
        if (ofs >= 8'h2C && ofs <= 8'h2F) return w[8 * (ofs - 8'h2C) +: 8];
        return 8'hFF;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One user request; refusal is compared when asked, the answer byte whenever a response arrives.
    task automatic op(input op_kind_t kd, input logic [23:0] ad,
        input logic ck_ref, input logic exp_ref, input logic [7:0] exp_d);
        int n;
        logic got_ref;
        logic got_done;
        n = 0;
        got_ref = 1'b0;
        got_done = 1'b0;
        while (usr_ready !== 1'b1 && n < 500) begin
            @(negedge mclk);
            n++;
        end
        @(posedge mclk);
        usr_valid <= 1'b1;
        usr_kind <= kd;
        usr_addr <= ad;
        @(posedge mclk);
        usr_valid <= 1'b0;
        n = 0;
        while (n < 500) begin
            @(negedge mclk);
            n++;
            if (usr_refused === 1'b1) got_ref = 1'b1;
            if (usr_done === 1'b1) got_done = 1'b1;
            if (usr_ready === 1'b1 && n >= 4) break;
        end
        if (ck_ref) check(32'(got_ref), 32'(exp_ref));
        if (got_done) check(32'(usr_data), 32'(exp_d));
    endtask

    task automatic settle(input logic all_idle);
        int n;
        n = 0;
        while (n < 500 && (lnk.halting !== 1'b0 || (all_idle &&
            (lnk.erasing !== 1'b0 || lnk.programming !== 1'b0)))) begin
            @(negedge mclk);
            n++;
        end
    endtask

    task automatic stop_test();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        stop_test();
    end

    initial begin
        void'($urandom(32'hFC5F));
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        for (int i = 8'h2A; i <= 8'h31; i++)
            op(K_DISCOVER, 24'(i), 1, 0, disc_byte(8'(i)));
        op(K_DISCOVER, 24'h2F, 1, 0, 8'h45);
        check(32'(usr_data[7]), 32'h0);
        $display("test discovery done");
        op(K_ERASE, 24'h030000, 1, 0, 8'hFF);
        op(K_SUSPEND, 24'h0, 1, 0, 8'hFF);
        settle(1'b0);
        check(32'(lnk.ers_susp), 32'h1);
        op(K_ERASE, 24'h050000, 1, 1, 8'hFF);
        op(K_PROGRAM, 24'h030200, 1, 1, 8'hFF);
        op(K_READ, 24'h03F000, 1, 1, 8'hFF);
        op(K_READ, 24'h040000, 1, 0, 8'hFF);
        op(K_PROGRAM, 24'h060400, 1, 0, 8'hFF);
        op(K_SUSPEND, 24'h0, 1, 0, 8'hFF);
        settle(1'b0);
        check(32'(lnk.prg_susp), 32'h1);
        op(K_ERASE, 24'h070000, 1, 1, 8'hFF);
        op(K_PROGRAM, 24'h080000, 1, 1, 8'hFF);
        op(K_READ, 24'h0605FF, 1, 1, 8'hFF);
        op(K_READ, 24'h060600, 1, 0, 8'hFF);
        op(K_RESUME, 24'h0, 1, 0, 8'hFF);
        op(K_SUSPEND, 24'h0, 1, 0, 8'hFF);
        settle(1'b1);
        check(32'(lnk.prg_susp), 32'h1);
        op(K_RESUME, 24'h0, 1, 0, 8'hFF);
        settle(1'b1);
        check(32'(lnk.prg_susp), 32'h0);
        op(K_RESUME, 24'h0, 1, 0, 8'hFF);
        op(K_SUSPEND, 24'h0, 1, 0, 8'hFF);
        settle(1'b0);
        check(32'(lnk.ers_susp), 32'h1);
        op(K_RESUME, 24'h0, 1, 0, 8'hFF);
        settle(1'b1);
        check(32'({lnk.ers_susp, lnk.prg_susp}), 32'h0);
        $display("test suspend done");
        op(K_SUSPEND, 24'h0, 1, 0, 8'hFF);
        repeat (HALT + 2) @(negedge mclk);
        check(32'({lnk.halting, lnk.ers_susp, lnk.prg_susp}), 32'h0);
        $display("test idle suspend done");
        repeat (60) begin
            k = op_kind_t'($urandom % 6);
            a = {6'h0, 2'($urandom), 6'h0, 10'($urandom)};
            if (k == K_DISCOVER) a = 24'h28 + 24'($urandom % 10);
            op(k, a, 0, 0, (k == K_DISCOVER) ? disc_byte(a[7:0]) : 8'hFF);
        end
        repeat (2) begin
            settle(1'b1);
            op(K_RESUME, 24'h0, 0, 0, 8'hFF);
        end
        settle(1'b1);
        $display("test random done");
        stop_test();
    end
endmodule // flash_suspend_resume_control_test
